// File: inc/soi_pkg.sv
package soi_pkg;
    // clock and timing
    localparam int unsigned SOI_CLK_HZ = 25_000_000;
    localparam int unsigned SOI_HZ_PER_MHZ = 1_000_000;
    localparam int unsigned SOI_MS_PER_S = 1_000;
    localparam int unsigned SOI_PWR_BLANK_S = 3;
    localparam int unsigned SOI_CMD_BLANK_S = 1;
    localparam int unsigned SOI_MIN_CYCLE_US = 500;
    localparam int unsigned SOI_LEGACY_CYCLE_MS = 2;
    localparam int unsigned SOI_LINK_RATE_MHZ = 10;
    localparam int unsigned SOI_LEGACY_RATE_MHZ = 4;
    localparam int unsigned SOI_WDT_TIMEOUT_MS = 10;
    localparam int unsigned SOI_QUAD_MAX_MPPS = 1;
    localparam int unsigned SOI_QUAD_PHASE_DEG = 90;
    localparam int unsigned SOI_PWR_BLANK_CYC = SOI_CLK_HZ * SOI_PWR_BLANK_S;
    localparam int unsigned SOI_CMD_BLANK_CYC = SOI_CLK_HZ * SOI_CMD_BLANK_S;
    localparam int unsigned SOI_MIN_CYCLE_CYC =
        (SOI_CLK_HZ / SOI_HZ_PER_MHZ) * SOI_MIN_CYCLE_US;
    localparam int unsigned SOI_LEGACY_CYCLE_CYC =
        (SOI_CLK_HZ / SOI_MS_PER_S) * SOI_LEGACY_CYCLE_MS;
    localparam int unsigned SOI_WDT_TIMEOUT_CYC =
        (SOI_CLK_HZ / SOI_MS_PER_S) * SOI_WDT_TIMEOUT_MS;

    localparam int unsigned SOI_CNT_W = 32;
    localparam int unsigned SOI_POS_W = 32;
    localparam int unsigned SOI_LATCH_N = 3;
    localparam int unsigned SOI_SYNC_W = 9;
    localparam logic [SOI_CNT_W-1:0] SOI_CNT_ONE = 32'h0000_0001;
    localparam logic [SOI_POS_W-1:0] SOI_POS_ONE = 32'h0000_0001;

    // synchronised pin positions
    localparam int unsigned SOI_SY_OP = 0;
    localparam int unsigned SOI_SY_PC = 1;
    localparam int unsigned SOI_SY_A = 2;
    localparam int unsigned SOI_SY_B = 3;
    localparam int unsigned SOI_SY_C = 4;
    localparam int unsigned SOI_SY_LAT = 5;
    localparam int unsigned SOI_SY_OPEN = 8;

    typedef enum logic [7:0] {
        SOI_CMD_NOP = 8'h00,
        param_read_cmd = 8'h01,
        param_write_cmd = 8'h02,
        nonvolatile_param_write_cmd = 8'h1c,
        SOI_CMD_SETUP = 8'h04,
        alarm_read_cmd = 8'h05,
        alarm_clear_cmd = 8'h06,
        sensor_on_cmd = 8'h23,
        adjust_cmd = 8'h3e,
        identity_read_cmd = 8'h03
    } soi_cmd_e;

    typedef enum logic [1:0] {
        SOI_LAT_INDEX = 2'h0,
        SOI_LAT_EXT1 = 2'h1,
        SOI_LAT_EXT2 = 2'h2,
        SOI_LAT_EXT3 = 2'h3
    } soi_lat_src_e;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic hist_sel;
        logic model_sel;
    } soi_cmd_s;

    typedef struct packed {
        logic param_corrupt;
        logic param_range;
        logic comm_err;
        logic wdt_err;
        logic enc_open;
        logic quad_err;
    } soi_fault_s;

    typedef struct packed {
        logic valid;
        soi_lat_src_e src;
        logic [SOI_POS_W-1:0] pos;
    } soi_latch_s;
endpackage : soi_pkg

// File: design/soi_sync.sv
`timescale 1ns/1ps
module soi_sync (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [soi_pkg::SOI_SYNC_W-1:0] async_in,
    output logic [soi_pkg::SOI_SYNC_W-1:0] sync_out
);
    import soi_pkg::*;

    typedef struct packed {
        logic [SOI_SYNC_W-1:0] meta;
        logic [SOI_SYNC_W-1:0] stable;
    } soi_sync_s;

    soi_sync_s state_reg;
    soi_sync_s state_next;

    always_comb begin
        state_next.meta = async_in;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stable;
endmodule : soi_sync

// File: design/soi_supervisor.sv
// What this block does
// - keep panel indicator dark about three seconds after power-up.
// - indicator dark while hand-held operator attached, lit again after.
// - blank indicator about one second on listed parameter/setup commands.
// - session start during restricted command raises command-incomplete alarm.
// - operator attach accepted while powered, no power cycle required.
// - link runs 10 MHz, cycle at least 500 us; legacy 4 MHz/2 ms.
// - decode A/B quadrature ninety degrees apart, up to 1 Mpps.
// - latch position on index phase or any of three latch inputs.
// - drive alarm lamp and network-communication lamp.
// - detect parameter, range, comm, watchdog and encoder-open faults.
`timescale 1ns/1ps
module soi_supervisor #(
    parameter logic [31:0] PWR_BLANK_CYC = soi_pkg::SOI_PWR_BLANK_CYC,
    parameter logic [31:0] CMD_BLANK_CYC = soi_pkg::SOI_CMD_BLANK_CYC,
    parameter logic [31:0] MIN_CYCLE_CYC = soi_pkg::SOI_MIN_CYCLE_CYC,
    parameter logic [31:0] WDT_TIMEOUT_CYC = soi_pkg::SOI_WDT_TIMEOUT_CYC
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // pins from outside the clock domain
    input wire logic operator_connector_in,
    input wire logic pc_session_in,
    input wire logic quad_a_in,
    input wire logic quad_b_in,
    input wire logic quad_c_in,
    input wire logic [soi_pkg::SOI_LATCH_N-1:0] ext_latch_in,
    input wire logic enc_open_in,
    // from network logic on the same clock
    input wire soi_pkg::soi_cmd_s cmd_in,
    input wire logic cmd_done_in,
    input wire logic frame_start_in,
    input wire logic link_err_in,
    input wire logic legacy_mode_in,
    input wire logic comm_active_in,
    input wire logic wdt_kick_in,
    input wire logic param_corrupt_in,
    input wire logic param_range_err_in,
    // outputs
    output logic panel_led_on_out,
    output logic alarm_lamp_out,
    output logic comm_lamp_out,
    output logic cmd_incomplete_alarm_out,
    output logic cmd_reject_out,
    output logic cmd_busy_out,
    output soi_pkg::soi_fault_s faults_out,
    output logic [soi_pkg::SOI_POS_W-1:0] position_out,
    output soi_pkg::soi_latch_s latch_out
);
    import soi_pkg::*;

    typedef struct packed {
        logic [SOI_CNT_W-1:0] pwr_cnt;
        logic pwr_done;
        logic [SOI_CNT_W-1:0] blank_cnt;
        logic op_q;
        logic pc_q;
        logic [1:0] ab_q;
        logic c_q;
        logic [SOI_LATCH_N-1:0] lat_q;
        logic exec;
        logic incomplete;
        logic reject;
        logic [SOI_POS_W-1:0] pos;
        soi_latch_s latch;
        soi_fault_s faults;
        logic [SOI_CNT_W-1:0] cyc_cnt;
        logic cyc_seen;
        logic [SOI_CNT_W-1:0] wdt_cnt;
        logic wdt_armed;
        logic led_on;
        logic alarm_lamp;
        logic comm_lamp;
    } soi_state_s;

    soi_state_s state_reg;
    soi_state_s state_next;
    logic [SOI_SYNC_W-1:0] pins_sync;

    // restricted while a hand-held operator or PC tool session is up
    function automatic logic soi_is_restricted(input logic [7:0] code);
        unique case (code)
            param_read_cmd, param_write_cmd, nonvolatile_param_write_cmd,
            SOI_CMD_SETUP, alarm_read_cmd, alarm_clear_cmd, sensor_on_cmd,
            adjust_cmd, identity_read_cmd: soi_is_restricted = 1'b1;
            default: soi_is_restricted = 1'b0;
        endcase
    endfunction : soi_is_restricted

    function automatic logic soi_blanks(input soi_cmd_s c);
        unique case (c.code)
            param_read_cmd, param_write_cmd, nonvolatile_param_write_cmd,
            SOI_CMD_SETUP, sensor_on_cmd, adjust_cmd: soi_blanks = 1'b1;
            alarm_read_cmd, alarm_clear_cmd: soi_blanks = c.hist_sel;
            identity_read_cmd: soi_blanks = c.model_sel;
            default: soi_blanks = 1'b0;
        endcase
    endfunction : soi_blanks

    function automatic logic soi_rise(input logic prev, input logic cur);
        soi_rise = cur & ~prev;
    endfunction : soi_rise

    // gray-order step: 2'b01 up, 2'b11 down, 2'b00 none, 2'b10 illegal
    function automatic logic [1:0] soi_quad_step(input logic [1:0] prev,
                                                 input logic [1:0] cur);
        logic [3:0] t;
        t = {prev, cur};
        unique case (t)
            4'h1, 4'h7, 4'he, 4'h8: soi_quad_step = 2'h1;
            4'h2, 4'hb, 4'hd, 4'h4: soi_quad_step = 2'h3;
            4'h0, 4'h5, 4'ha, 4'hf: soi_quad_step = 2'h0;
            default: soi_quad_step = 2'h2;
        endcase
    endfunction : soi_quad_step

    soi_sync u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .async_in({enc_open_in, ext_latch_in, quad_c_in, quad_b_in,
                   quad_a_in, pc_session_in, operator_connector_in}),
        .sync_out(pins_sync)
    );

    logic op_now;
    logic pc_now;
    logic [1:0] ab_now;
    logic c_now;
    logic [SOI_LATCH_N-1:0] lat_now;
    logic session;
    logic session_start;
    logic restricted;
    logic accept;
    logic clear_req;
    logic [1:0] step;
    logic short_cycle;
    logic wdt_fire;
    logic [SOI_CNT_W-1:0] min_cycle;

    always_comb begin
        op_now = pins_sync[SOI_SY_OP];
        pc_now = pins_sync[SOI_SY_PC];
        ab_now = {pins_sync[SOI_SY_B], pins_sync[SOI_SY_A]};
        c_now = pins_sync[SOI_SY_C];
        lat_now = pins_sync[SOI_SY_LAT +: SOI_LATCH_N];
        session = op_now | pc_now;
        // attach is live at any time, no power cycle needed
        session_start = soi_rise(state_reg.op_q, op_now) |
                        soi_rise(state_reg.pc_q, pc_now);
        restricted = cmd_in.valid & soi_is_restricted(cmd_in.code);
        // refuse restricted traffic that the host should not send now
        accept = restricted & ~session;
        clear_req = accept & (cmd_in.code == alarm_clear_cmd);
        step = soi_quad_step(state_reg.ab_q, ab_now);
        min_cycle = legacy_mode_in ? SOI_LEGACY_CYCLE_CYC[SOI_CNT_W-1:0]
                                   : MIN_CYCLE_CYC;
        short_cycle = frame_start_in & state_reg.cyc_seen &
                      (state_reg.cyc_cnt < min_cycle);
        wdt_fire = state_reg.wdt_armed & ~wdt_kick_in &
                   (state_reg.wdt_cnt >= WDT_TIMEOUT_CYC);
    end

    always_comb begin
        state_next = state_reg;
        state_next.op_q = op_now;
        state_next.pc_q = pc_now;
        state_next.ab_q = ab_now;
        state_next.c_q = c_now;
        state_next.lat_q = lat_now;
        state_next.reject = restricted & session;
        state_next.latch.valid = 1'b0;

        // power-up blanking
        if (!state_reg.pwr_done) begin
            if (state_reg.pwr_cnt >= PWR_BLANK_CYC - SOI_CNT_ONE) begin
                state_next.pwr_done = 1'b1;
            end else begin
                state_next.pwr_cnt = state_reg.pwr_cnt + SOI_CNT_ONE;
            end
        end

        // command blanking, retriggered by every qualifying command
        if (cmd_in.valid && soi_blanks(cmd_in)) begin
            state_next.blank_cnt = CMD_BLANK_CYC;
        end else if (state_reg.blank_cnt != '0) begin
            state_next.blank_cnt = state_reg.blank_cnt - SOI_CNT_ONE;
        end

        // restricted command execution and abort on session start
        if (state_reg.exec && session_start) begin
            state_next.exec = 1'b0;
        end else if (accept) begin
            state_next.exec = 1'b1;
        end else if (cmd_done_in) begin
            state_next.exec = 1'b0;
        end
        if (state_reg.exec && session_start) begin
            state_next.incomplete = 1'b1;
        end else if (clear_req) begin
            state_next.incomplete = 1'b0;
        end

        // quadrature position counter
        unique case (step)
            2'h1: state_next.pos = state_reg.pos + SOI_POS_ONE;
            2'h3: state_next.pos = state_reg.pos - SOI_POS_ONE;
            default: state_next.pos = state_reg.pos;
        endcase

        // position latch, index phase has priority
        if (soi_rise(state_reg.c_q, c_now)) begin
            state_next.latch.valid = 1'b1;
            state_next.latch.src = SOI_LAT_INDEX;
            state_next.latch.pos = state_reg.pos;
        end else begin
            for (int i = SOI_LATCH_N - 1; i >= 0; i--) begin
                if (soi_rise(state_reg.lat_q[i], lat_now[i])) begin
                    state_next.latch.valid = 1'b1;
                    state_next.latch.src = soi_lat_src_e'(i[1:0] + 2'h1);
                    state_next.latch.pos = state_reg.pos;
                end
            end
        end

        // link cycle timer
        if (frame_start_in) begin
            state_next.cyc_cnt = '0;
            state_next.cyc_seen = 1'b1;
        end else if (state_reg.cyc_cnt != '1) begin
            state_next.cyc_cnt = state_reg.cyc_cnt + SOI_CNT_ONE;
        end

        // watchdog, armed by the first kick
        if (wdt_kick_in) begin
            state_next.wdt_cnt = '0;
            state_next.wdt_armed = 1'b1;
        end else if (state_reg.wdt_armed && !wdt_fire) begin
            state_next.wdt_cnt = state_reg.wdt_cnt + SOI_CNT_ONE;
        end else if (wdt_fire) begin
            state_next.wdt_armed = 1'b0;
            state_next.wdt_cnt = '0;
        end

        // sticky faults, a new detection beats alarm clear
        if (clear_req) begin
            state_next.faults = '0;
        end
        if (param_corrupt_in) begin
            state_next.faults.param_corrupt = 1'b1;
        end
        if (param_range_err_in) begin
            state_next.faults.param_range = 1'b1;
        end
        if (link_err_in || short_cycle) begin
            state_next.faults.comm_err = 1'b1;
        end
        if (wdt_fire) begin
            state_next.faults.wdt_err = 1'b1;
        end
        if (pins_sync[SOI_SY_OPEN]) begin
            state_next.faults.enc_open = 1'b1;
        end
        if (step == 2'h2) begin
            state_next.faults.quad_err = 1'b1;
        end

        // indicators
        state_next.led_on = state_next.pwr_done & ~op_now &
                            (state_next.blank_cnt == '0);
        state_next.alarm_lamp = (|state_next.faults) |
                                state_next.incomplete;
        state_next.comm_lamp = comm_active_in &
                               ~state_next.faults.comm_err;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign panel_led_on_out = state_reg.led_on;
    assign alarm_lamp_out = state_reg.alarm_lamp;
    assign comm_lamp_out = state_reg.comm_lamp;
    assign cmd_incomplete_alarm_out = state_reg.incomplete;
    assign cmd_reject_out = state_reg.reject;
    assign cmd_busy_out = state_reg.exec;
    assign faults_out = state_reg.faults;
    assign position_out = state_reg.pos;
    assign latch_out = state_reg.latch;
endmodule : soi_supervisor

// File: verification/soi_supervisor_assertions.sv
`timescale 1ns/1ps
module soi_supervisor_assertions #(
    parameter logic [31:0] PWR_BLANK_CYC = soi_pkg::SOI_PWR_BLANK_CYC,
    parameter logic [31:0] CMD_BLANK_CYC = soi_pkg::SOI_CMD_BLANK_CYC
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic operator_connector_in,
    input wire logic pc_session_in,
    input wire logic quad_c_in,
    input wire logic enc_open_in,
    input wire soi_pkg::soi_cmd_s cmd_in,
    input wire logic cmd_done_in,
    input wire logic link_err_in,
    input wire logic comm_active_in,
    input wire logic panel_led_on_out,
    input wire logic alarm_lamp_out,
    input wire logic comm_lamp_out,
    input wire logic cmd_incomplete_alarm_out,
    input wire logic cmd_reject_out,
    input wire logic cmd_busy_out,
    input wire soi_pkg::soi_fault_s faults_out,
    input wire soi_pkg::soi_latch_s latch_out
);
    import soi_pkg::*;
    logic [31:0] up_cnt_reg;
    logic restr_cmd;
    logic blank_cmd;
    assign restr_cmd = cmd_in.valid && (cmd_in.code inside {param_read_cmd,
        param_write_cmd, nonvolatile_param_write_cmd, SOI_CMD_SETUP,
        sensor_on_cmd, adjust_cmd});
    assign blank_cmd = restr_cmd || (cmd_in.valid && ((cmd_in.hist_sel &&
        cmd_in.code inside {alarm_read_cmd, alarm_clear_cmd}) ||
        (cmd_in.model_sel && cmd_in.code == identity_read_cmd)));

    // cycles since reset release, saturating
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            up_cnt_reg <= '0;
        end else if (up_cnt_reg != '1) begin
            up_cnt_reg <= up_cnt_reg + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence idle_s;
        (!operator_connector_in && !pc_session_in) [*3];
    endsequence
    sequence sess_s;
        (operator_connector_in || pc_session_in) [*3];
    endsequence
    sequence hold_s;
        (cmd_busy_out && !cmd_done_in && !operator_connector_in) [*3];
    endsequence

    a_pwr_blank: assert property (
        panel_led_on_out |-> up_cnt_reg >= PWR_BLANK_CYC)
        else $error("led lit inside power-up blank");
    a_op_dark: assert property (
        operator_connector_in [*3] |=> !panel_led_on_out)
        else $error("led lit with operator attached");
    a_cmd_blank: assert property (
        blank_cmd |=> !panel_led_on_out [*8])
        else $error("led not blanked after command");
    a_busy_start: assert property (
        idle_s ##0 restr_cmd |=> cmd_busy_out)
        else $error("busy missing after command");
    a_session_reject: assert property (
        sess_s ##0 restr_cmd |=> cmd_reject_out)
        else $error("reject missing during session");
    a_abort_alarm: assert property (
        $rose(pc_session_in) ##0 hold_s |-> ##[1:2] cmd_incomplete_alarm_out)
        else $error("incomplete alarm missing");
    a_alarm_sticky: assert property (
        cmd_incomplete_alarm_out && !(cmd_in.valid &&
        cmd_in.code == alarm_clear_cmd) |=> cmd_incomplete_alarm_out)
        else $error("incomplete alarm dropped");
    a_lamp_alarm: assert property (
        cmd_incomplete_alarm_out || (|faults_out) |-> alarm_lamp_out)
        else $error("alarm lamp dark with alarm");
    a_comm_lamp: assert property (
        !comm_active_in |=> !comm_lamp_out)
        else $error("comm lamp lit without traffic");
    a_link_err: assert property (
        link_err_in |=> faults_out.comm_err)
        else $error("link error not flagged");
    a_enc_open: assert property (
        enc_open_in [*3] |=> faults_out.enc_open)
        else $error("encoder open not flagged");
    a_index_latch: assert property (
        $rose(quad_c_in) |-> ##[2:4] (latch_out.valid &&
        latch_out.src == SOI_LAT_INDEX))
        else $error("index latch missing");
endmodule : soi_supervisor_assertions

bind soi_supervisor soi_supervisor_assertions #(
    .PWR_BLANK_CYC(PWR_BLANK_CYC),
    .CMD_BLANK_CYC(CMD_BLANK_CYC)
) u_chk (
    .sys_clk_in, .rst_in, .operator_connector_in, .pc_session_in,
    .quad_c_in, .enc_open_in, .cmd_in, .cmd_done_in, .link_err_in,
    .comm_active_in, .panel_led_on_out, .alarm_lamp_out, .comm_lamp_out,
    .cmd_incomplete_alarm_out, .cmd_reject_out, .cmd_busy_out,
    .faults_out, .latch_out
);

// File: verification/soi_host_model.sv
`timescale 1ns/1ps
module soi_host_model (
    input wire logic sys_clk_in,
    output soi_pkg::soi_cmd_s cmd_out,
    output logic cmd_done_out,
    output logic frame_start_out,
    output logic link_err_out,
    output logic comm_active_out,
    output logic wdt_kick_out
);
    import soi_pkg::*;
    initial begin
        cmd_out = '0;
        {link_err_out, wdt_kick_out, frame_start_out, cmd_done_out} = 4'h0;
        comm_active_out = 1'b0;
    end

    // q is {history select, model select}
    task automatic send(input logic [7:0] code, input logic [1:0] q);
        @(negedge sys_clk_in);
        cmd_out = {1'b1, code, q};
        @(negedge sys_clk_in);
        cmd_out = '0;
    endtask : send

    // sel: 0 done, 1 frame start, 2 watchdog kick, 3 link error
    task automatic pulse(input int sel);
        @(negedge sys_clk_in);
        {link_err_out, wdt_kick_out, frame_start_out, cmd_done_out} =
            4'h1 << sel;
        @(negedge sys_clk_in);
        {link_err_out, wdt_kick_out, frame_start_out, cmd_done_out} = 4'h0;
    endtask : pulse

    // frame starts exactly gap cycles apart
    task automatic frames(input int n, input int gap);
        repeat (n) begin
            pulse(1);
            repeat (gap - 2) @(negedge sys_clk_in);
        end
    endtask : frames
endmodule : soi_host_model

// File: verification/soi_supervisor_tb_top.sv
`timescale 1ns/1ps
module soi_supervisor_tb_top;
    import soi_pkg::*;
    localparam logic [31:0] PWR = 32'h0000_0032;
    localparam logic [31:0] CMD = 32'h0000_0014;
    localparam logic [31:0] MINC = 32'h0000_001e;
    localparam logic [31:0] WDT = 32'h0000_0028;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic op = 1'b0, pc = 1'b0, qa = 1'b0, qb = 1'b0, qc = 1'b0;
    logic eo = 1'b0, pcor = 1'b0, prng = 1'b0, legacy = 1'b0;
    logic [2:0] ext = 3'h0;
    soi_cmd_s cmd;
    logic done, frm, lerr, cact, kick, led, alm, com, inc, rej, busy;
    soi_fault_s flt;
    logic [31:0] pos;
    soi_latch_s lat;
    int bad_count = 0;
    int checks_done = 0;
    int cyc_cnt = 0;

    always #20 sys_clk_in = ~sys_clk_in;

    soi_host_model host (.sys_clk_in(sys_clk_in), .cmd_out(cmd),
        .cmd_done_out(done), .frame_start_out(frm), .link_err_out(lerr),
        .comm_active_out(cact), .wdt_kick_out(kick));

    soi_supervisor #(.PWR_BLANK_CYC(PWR), .CMD_BLANK_CYC(CMD),
        .MIN_CYCLE_CYC(MINC), .WDT_TIMEOUT_CYC(WDT)) dut (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .operator_connector_in(op), .pc_session_in(pc), .quad_a_in(qa),
        .quad_b_in(qb), .quad_c_in(qc), .ext_latch_in(ext),
        .enc_open_in(eo), .cmd_in(cmd), .cmd_done_in(done),
        .frame_start_in(frm), .link_err_in(lerr), .legacy_mode_in(legacy),
        .comm_active_in(cact), .wdt_kick_in(kick),
        .param_corrupt_in(pcor), .param_range_err_in(prng),
        .panel_led_on_out(led), .alarm_lamp_out(alm), .comm_lamp_out(com),
        .cmd_incomplete_alarm_out(inc), .cmd_reject_out(rej),
        .cmd_busy_out(busy), .faults_out(flt), .position_out(pos),
        .latch_out(lat));

    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : cyc

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic t_power;
        cyc(PWR - 2);
        chk("led in power blank", 0, led);
        cyc(5);
        chk("led after power blank", 1, led);
    endtask : t_power

    task automatic t_blank;
        logic [7:0] codes [9] = '{param_read_cmd, param_write_cmd,
            nonvolatile_param_write_cmd, SOI_CMD_SETUP, sensor_on_cmd,
            adjust_cmd, alarm_read_cmd, alarm_clear_cmd, identity_read_cmd};
        foreach (codes[i]) begin
            host.send(codes[i], 2'h3);
            cyc(1);
            chk("blank led", 0, led);
            chk("busy", 1, busy);
            host.pulse(0);
            cyc(CMD + 2);
            chk("relit led", 1, led);
        end
        host.send(alarm_read_cmd, 2'h0);
        cyc(1);
        chk("plain alarm read", 1, led);
        host.pulse(0);
        host.send(param_write_cmd, 2'h0);
        cyc(8);
        host.send(param_write_cmd, 2'h0);
        cyc(CMD - 4);
        chk("reloaded blank", 0, led);
        cyc(8);
        chk("reload relit", 1, led);
        host.pulse(0);
    endtask : t_blank

    task automatic t_operator;
        op = 1'b1;
        cyc(4);
        chk("led with operator", 0, led);
        host.send(param_read_cmd, 2'h0);
        chk("refused cmd", 1, rej);
        cyc(1);
        chk("refused not busy", 0, busy);
        op = 1'b0;
        // refused command still blanks, so wait out its blank as well
        cyc(CMD + 2);
        chk("led after detach", 1, led);
    endtask : t_operator

    task automatic t_abort;
        host.send(param_read_cmd, 2'h0);
        cyc(1);
        chk("busy before session", 1, busy);
        pc = 1'b1;
        cyc(5);
        chk("incomplete alarm", 1, inc);
        chk("aborted busy", 0, busy);
        chk("alarm lamp", 1, alm);
        pc = 1'b0;
        cyc(4);
        host.send(alarm_clear_cmd, 2'h2);
        cyc(1);
        chk("alarm cleared", 0, inc);
        host.pulse(0);
    endtask : t_abort

    task automatic t_faults;
        host.comm_active_out = 1'b1;
        host.frames(3, MINC + 2);
        chk("spaced frames", 0, flt.comm_err);
        chk("comm lamp", 1, com);
        host.frames(2, MINC - 10);
        cyc(2);
        chk("short frame gap", 1, flt.comm_err);
        chk("comm lamp fault", 0, com);
        host.pulse(3);
        host.pulse(2);
        eo = 1'b1;
        pcor = 1'b1;
        prng = 1'b1;
        cyc(WDT + 4);
        chk("fault set", 64'h3e, flt);
        eo = 1'b0;
        pcor = 1'b0;
        prng = 1'b0;
        cyc(4);
        host.send(alarm_clear_cmd, 2'h2);
        host.pulse(0);
        chk("faults cleared", 0, flt);
        chk("alarm lamp off", 0, alm);
        // gap legal for the fast link is short for the old generation
        legacy = 1'b1;
        host.frames(2, MINC + 2);
        chk("legacy short cycle", 1, flt.comm_err);
        legacy = 1'b0;
    endtask : t_faults

    task automatic t_quad;
        logic [1:0] fwd [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
        foreach (fwd[i]) begin
            {qb, qa} = fwd[i];
            cyc(4);
        end
        chk("count up", 4, pos);
        qc = 1'b1;
        cyc(3);
        chk("index latch", {1'b1, SOI_LAT_INDEX, 32'h4}, lat);
        qc = 1'b0;
        {qb, qa} = 2'h2;
        cyc(4);
        {qb, qa} = 2'h3;
        cyc(4);
        chk("count down", 2, pos);
        for (int i = 0; i < 3; i++) begin
            ext = 3'h1 << i;
            cyc(3);
            chk("ext latch", {1'b1, 2'(i + 1), 32'h2}, lat);
            ext = 3'h0;
            cyc(2);
        end
        {qb, qa} = 2'h0;
        cyc(4);
        chk("double step", 1, flt.quad_err);
    endtask : t_quad

    always @(posedge sys_clk_in) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            bad_count++;
            stop_test();
        end
    end

    initial begin
        cyc(8);
        rst_in = 1'b0;
        t_power();
        t_blank();
        t_operator();
        t_abort();
        t_faults();
        t_quad();
        stop_test();
    end
endmodule : soi_supervisor_tb_top
